/* core/mmec_pkg.sv */
package mmec_pkg;

    localparam int MMEC_AW = 8;
    localparam int MMEC_DW = 32;

    // Register byte addresses, one 32-bit word each.
    localparam logic [7:0] MMEC_REG_CTRL = 8'h00;
    localparam logic [7:0] MMEC_REG_LIMIT = 8'h04;
    localparam logic [7:0] MMEC_REG_COUNT = 8'h08;
    localparam logic [7:0] MMEC_REG_RESULT = 8'h0C;
    localparam logic [7:0] MMEC_REG_STATUS = 8'h10;

    // Function codes held in the mode field of the control register.
    localparam logic [2:0] MMEC_MODULO_UP_DOWN_MODE = 3'h0;
    localparam logic [2:0] MMEC_COUNT_DIRECTION_MODE = 3'h1;
    localparam logic [2:0] MMEC_MODULO_COUNT_DIRECTION_MODE = 3'h2;
    localparam logic [2:0] MMEC_A_OVER_B_MODE = 3'h3;
    localparam logic [2:0] MMEC_AVG_PERIOD_MODE = 3'h4;
    localparam logic [2:0] MMEC_GATED_SINGLE_INTERVAL_MODE = 3'h5;
    localparam logic [2:0] MMEC_ALL_CHANNEL_RATE_CONFIG = 3'h6;

    localparam int MMEC_CTRL_W = 9;
    localparam logic [8:0] MMEC_CTRL_RST = 9'h000;
    localparam logic [15:0] MMEC_LIMIT_RST = 16'h0002;
    localparam int MMEC_STAT_BUSY_BIT = 0;
    localparam int MMEC_STAT_READY_BIT = 1;
    localparam int MMEC_STAT_W = 2;

    // Frequency gate time and its length in reference clock cycles.
    localparam int MMEC_CLK_KHZ = 125000;
    localparam int MMEC_GATE_MS = 1000;
    localparam int MMEC_GATE_CYCLES = MMEC_GATE_MS * MMEC_CLK_KHZ;
    localparam int MMEC_DIV_STEPS = 32;
    localparam logic [5:0] MMEC_DIV_STEPS_V = 6'h20;

    typedef struct packed {
        logic trigger;
        logic irq_en;
        logic b_level;
        logic quad;
        logic b_fall;
        logic a_fall;
        logic [2:0] mode;
    } mmec_ctrl_s;

    typedef enum logic [3:0] {
        MMEC_IDLE = 4'h1,
        MMEC_WAIT = 4'h2,
        MMEC_RUN = 4'h4,
        MMEC_DIV = 4'h8
    } mmec_state_e;

endpackage

/* core/mmec_channel.sv */
`timescale 1ns/1ps
// Overview of operation
// - Modulo up/down: A edges count up, B edges count down, range 0..modulus-1.
// - Up-count at modulus-1 wraps to zero and counting goes on.
// - Down-count at zero wraps to modulus-1 and counting goes on.
// - Modulo up/down never raises an interrupt.
// - Up/down and direction counting start only on a trigger.
// - Count/direction: A edges count up when B equals direction level, else down.
// - Signed count wraps from maximum positive to most negative on up-count.
// - Signed count wraps from most negative to maximum positive on down-count.
// - Count/direction modes, plain or modulo, raise no interrupt.
// - Quadrature counts both A transitions, two counts per A period.
// - Quadrature direction is up whenever B leads A.
// - Quadrature suits count/direction only; other functions then count double.
// - Modulo count/direction stays in 0..modulus-1, wrapping both ways.
// - Ratio counts A edges over N B periods, reports A count over N.
// - Ratio starts on first B edge after trigger; reading-available at end.
// - Averaged period averages N A periods, B ignored.
// - Averaged period starts on first A edge after trigger; flag at end.
// - Gated single period measures only the Nth gated A period.
// - Gated single period counts A periods only while B equals gate level.
// - Gated single period flags reading-available after Nth gated period.
// - Rate configuration measures input frequency over a gate, nothing else.
// - Rate configuration flags reading-available when its measurement ends.
module mmec_channel
    import mmec_pkg::*;
#(
    parameter int GATE_CYCLES = MMEC_GATE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [MMEC_AW-1:0] addr,
    input wire logic [MMEC_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [MMEC_DW-1:0] rdata,
    input wire logic a_in,
    input wire logic b_in,
    input wire logic trig_in,
    output logic reading_avail
);

    // A gate shorter than two cycles leaves no room to count a single edge.
    generate
        if (GATE_CYCLES < 2)
        begin : g_bad_gate
            $error("GATE_CYCLES must be at least 2");
        end
    endgenerate

    mmec_ctrl_s ctrl;
    logic [15:0] limit;
    logic [31:0] cnt;
    logic [31:0] ticks;
    logic [15:0] per;
    logic [31:0] result;
    logic ready;
    mmec_state_e state;
    logic [32:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
    logic [5:0] div_cnt;
    logic a_s1, a_s2, a_d;
    logic b_s1, b_s2, b_d;
    logic t_s1, t_s2, t_d;

    // Synchronisers; the first stage feeds only the second.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            a_s1 <= 1'b0;
            a_s2 <= 1'b0;
            a_d <= 1'b0;
            b_s1 <= 1'b0;
            b_s2 <= 1'b0;
            b_d <= 1'b0;
            t_s1 <= 1'b0;
            t_s2 <= 1'b0;
            t_d <= 1'b0;
        end
        else if (ce)
        begin
            a_s1 <= a_in;
            a_s2 <= a_s1;
            a_d <= a_s2;
            b_s1 <= b_in;
            b_s2 <= b_s1;
            b_d <= b_s2;
            t_s1 <= trig_in;
            t_s2 <= t_s1;
            t_d <= t_s2;
        end
    end

    wire a_rise = a_s2 & ~a_d;
    wire a_fallw = ~a_s2 & a_d;
    wire b_rise = b_s2 & ~b_d;
    wire b_fallw = ~b_s2 & b_d;
    // Both A transitions count in quadrature, in every function alike.
    wire a_edge = ctrl.quad ? (a_rise | a_fallw) : (ctrl.a_fall ? a_fallw : a_rise);
    wire b_edge = ctrl.b_fall ? b_fallw : b_rise;
    wire b_match = (b_s2 == ctrl.b_level);
    // B leads A when B is already high at A's rise or already low at A's fall.
    wire dir_up = ctrl.quad ? (a_rise ? b_s2 : ~b_s2) : b_match;

    wire is_mud = (ctrl.mode == MMEC_MODULO_UP_DOWN_MODE);
    wire is_cd = (ctrl.mode == MMEC_COUNT_DIRECTION_MODE);
    wire is_cdm = (ctrl.mode == MMEC_MODULO_COUNT_DIRECTION_MODE);
    wire is_rat = (ctrl.mode == MMEC_A_OVER_B_MODE);
    wire is_avg = (ctrl.mode == MMEC_AVG_PERIOD_MODE);
    wire is_gsi = (ctrl.mode == MMEC_GATED_SINGLE_INTERVAL_MODE);
    wire is_frq = (ctrl.mode == MMEC_ALL_CHANNEL_RATE_CONFIG);
    wire is_count = is_mud | is_cd | is_cdm;
    wire modular = is_mud | is_cdm;

    // Coincident A and B edges in up/down cancel, so no edge is lost.
    wire up_ev = is_mud ? (a_edge & ~b_edge) : (a_edge & dir_up);
    wire dn_ev = is_mud ? (b_edge & ~a_edge) : (a_edge & ~dir_up);
    wire [31:0] mod_top = {16'h0000, limit} - 32'h00000001;
    // Plain 32-bit add and subtract wrap the signed count in both directions.
    wire [31:0] inc_val = (modular && cnt == mod_top) ? 32'h00000000 : cnt + 32'h00000001;
    wire [31:0] dec_val = (modular && cnt == 32'h0) ? mod_top : cnt - 32'h00000001;
    wire [31:0] next_cnt_count = up_ev ? inc_val : (dn_ev ? dec_val : cnt);

    wire ctrl_wr = wr && addr == MMEC_REG_CTRL;
    wire limit_wr = wr && addr == MMEC_REG_LIMIT;
    wire stat_wr = wr && addr == MMEC_REG_STATUS;
    wire sw_trig = ctrl_wr && wdata[MMEC_CTRL_W-1];
    wire hw_trig = t_s2 & ~t_d;
    // A control write without the trigger bit parks the channel idle.
    wire park = ctrl_wr && !wdata[MMEC_CTRL_W-1];
    wire trig = sw_trig | (hw_trig & ~ctrl_wr);
    // A trigger written together with a new mode must start that mode, not the old one.
    wire [2:0] trig_mode = ctrl_wr ? wdata[2:0] : ctrl.mode;
    wire trig_run = (trig_mode == MMEC_MODULO_UP_DOWN_MODE) |
                    (trig_mode == MMEC_COUNT_DIRECTION_MODE) |
                    (trig_mode == MMEC_MODULO_COUNT_DIRECTION_MODE) |
                    (trig_mode == MMEC_ALL_CHANNEL_RATE_CONFIG);

    // Start events after the arming trigger.
    wire start_ev = is_rat ? b_edge : (is_avg ? a_edge : (a_edge & b_match));
    wire gated_a = a_edge & b_match;
    wire [15:0] per_inc = per + 16'h0001;
    wire rat_done = is_rat && b_edge && per_inc == limit;
    wire avg_done = is_avg && a_edge && per_inc == limit;
    wire gsi_done = is_gsi && gated_a && per_inc == limit;
    wire frq_done = is_frq && ticks == 32'(GATE_CYCLES - 1);
    wire run_done = rat_done | avg_done | gsi_done | frq_done;
    // Numerator and denominator handed to the divider at completion.
    wire [31:0] a_acc = cnt + {31'h0, a_edge};
    wire [31:0] num_sel = (is_rat | is_frq) ? a_acc : ticks;
    wire [31:0] den_sel = (is_rat | is_avg) ? {16'h0000, limit} : 32'h00000001;

    wire [32:0] rem_sh = {rem[31:0], quo[31]};
    wire [32:0] diff = rem_sh - {1'b0, den};
    wire div_last = (state == MMEC_DIV) && div_cnt == 6'h01;
    // Counting modes never reach the divider, so they never set the flag.
    wire set_ready = div_last;
    wire clr_ready = stat_wr && wdata[MMEC_STAT_READY_BIT];
    wire next_ready = set_ready | (ready & ~clr_ready);

    wire [31:0] ctrl_rd = {{(32 - MMEC_CTRL_W + 1){1'b0}}, ctrl[MMEC_CTRL_W-2:0]};
    wire [31:0] stat_rd = {30'h0, ready, state != MMEC_IDLE};
    wire [31:0] rd_mux = (addr == MMEC_REG_CTRL) ? ctrl_rd :
                         (addr == MMEC_REG_LIMIT) ? {16'h0000, limit} :
                         (addr == MMEC_REG_COUNT) ? cnt :
                         (addr == MMEC_REG_RESULT) ? result :
                         (addr == MMEC_REG_STATUS) ? stat_rd : 32'h00000000;

    // Register file and read port.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl <= MMEC_CTRL_RST;
            limit <= MMEC_LIMIT_RST;
            rdata <= 32'h00000000;
            ready <= 1'b0;
            reading_avail <= 1'b0;
        end
        else if (ce)
        begin
            if (ctrl_wr)
            begin
                ctrl <= {1'b0, wdata[MMEC_CTRL_W-2:0]};
            end
            if (limit_wr)
            begin
                limit <= wdata[15:0];
            end
            if (rd)
            begin
                rdata <= rd_mux;
            end
            ready <= next_ready;
            // A flag left over from a measurement must not interrupt a counting mode.
            reading_avail <= next_ready & ctrl.irq_en & ~is_count;
        end
    end

    // Measurement sequencer.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= MMEC_IDLE;
            cnt <= 32'h00000000;
            ticks <= 32'h00000000;
            per <= 16'h0000;
        end
        else if (ce)
        begin
            if (trig)
            begin
                cnt <= 32'h00000000;
                ticks <= 32'h00000000;
                per <= 16'h0000;
                state <= trig_run ? MMEC_RUN : MMEC_WAIT;
            end
            else if (park)
            begin
                state <= MMEC_IDLE;
            end
            else
            begin
                unique case (state)
                    MMEC_IDLE:
                    begin
                        state <= MMEC_IDLE;
                    end
                    MMEC_WAIT:
                    begin
                        if (start_ev)
                        begin
                            state <= MMEC_RUN;
                            ticks <= 32'h00000001;
                        end
                    end
                    MMEC_RUN:
                    begin
                        if (is_count)
                        begin
                            cnt <= next_cnt_count;
                        end
                        else if (run_done)
                        begin
                            state <= MMEC_DIV;
                        end
                        else
                        begin
                            ticks <= ticks + 32'h00000001;
                            if (is_rat | is_frq)
                            begin
                                cnt <= a_acc;
                            end
                            if ((is_rat & b_edge) | (is_avg & a_edge))
                            begin
                                per <= per_inc;
                            end
                            // Only the last gated period is timed, so restart on each.
                            if (is_gsi & gated_a)
                            begin
                                per <= per_inc;
                                ticks <= 32'h00000001;
                            end
                        end
                    end
                    MMEC_DIV:
                    begin
                        if (div_last)
                        begin
                            state <= MMEC_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Restoring divider, one quotient bit per cycle; shared by all measurements.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rem <= 33'h000000000;
            quo <= 32'h00000000;
            den <= 32'h00000001;
            div_cnt <= 6'h00;
            result <= 32'h00000000;
        end
        else if (ce)
        begin
            if (state == MMEC_RUN && !is_count && run_done && !trig && !park)
            begin
                rem <= 33'h000000000;
                quo <= num_sel;
                den <= den_sel;
                div_cnt <= MMEC_DIV_STEPS_V;
            end
            else if (state == MMEC_DIV)
            begin
                div_cnt <= div_cnt - 6'h01;
                if (!diff[32])
                begin
                    rem <= diff;
                    quo <= {quo[30:0], 1'b1};
                end
                else
                begin
                    rem <= rem_sh;
                    quo <= {quo[30:0], 1'b0};
                end
                if (div_last)
                begin
                    result <= {quo[30:0], ~diff[32]};
                end
            end
        end
    end

endmodule // mmec_channel

/* verif/mmec_channel_assertions.sv */
`timescale 1ns/1ps
module mmec_channel_chk
    import mmec_pkg::*;
#(
    parameter int GATE_CYCLES = MMEC_GATE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [MMEC_AW-1:0] addr,
    input wire logic [MMEC_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [MMEC_DW-1:0] rdata,
    input wire logic a_in,
    input wire logic b_in,
    input wire logic trig_in,
    input wire logic reading_avail
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0] mode_q;
    logic irq_q;
    logic [15:0] lim_q;
    wire bus_rd = rd && ce;
    wire bus_wr = wr && ce;
    wire counting = (mode_q <= 3'h2);
    // Shadows of mode and limit; the range check assumes the limit is set before a trigger.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_q <= 3'h0;
            irq_q <= 1'b0;
            lim_q <= 16'h0002;
        end
        else if (bus_wr && addr == MMEC_REG_CTRL)
        begin
            mode_q <= wdata[2:0];
            irq_q <= wdata[7];
        end
        else if (bus_wr && addr == MMEC_REG_LIMIT)
            lim_q <= wdata[15:0];
    end
    chk_reset_clear: assert property ($fell(rst) |-> rdata == 32'h0 && !reading_avail)
        else $error("outputs not clear after reset");
    chk_unmapped_zero: assert property (bus_rd && addr > 8'h10 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_ctrl_upper: assert property (bus_rd && addr == MMEC_REG_CTRL |=> rdata[31:8] == 24'h0)
        else $error("control readback upper bits set");
    chk_limit_upper: assert property (bus_rd && addr == MMEC_REG_LIMIT |=> rdata[31:16] == 16'h0)
        else $error("limit readback upper bits set");
    chk_status_upper: assert property (bus_rd && addr == MMEC_REG_STATUS |=> rdata[31:2] == 30'h0)
        else $error("status readback upper bits set");
    chk_rdata_hold: assert property (!bus_rd |=> $stable(rdata))
        else $error("read data changed without a read");
    chk_avail_mode: assert property ($rose(reading_avail) |-> !counting && irq_q)
        else $error("reading available raised in counting mode or while disabled");
    chk_avail_fall: assert property ($fell(reading_avail) |-> $past(bus_wr) || $past(bus_wr, 2))
        else $error("reading available dropped without a write");
    chk_count_modulo: assert property (bus_rd && addr == MMEC_REG_COUNT &&
        (mode_q == 3'h0 || mode_q == 3'h2) |=> rdata < {16'h0, lim_q})
        else $error("modulo count out of range");
    cover property ($rose(reading_avail));
    cover property (bus_rd && addr == MMEC_REG_COUNT && counting);
    cover property (bus_wr && addr == MMEC_REG_STATUS && wdata[1]);
endmodule // mmec_channel_chk
bind mmec_channel mmec_channel_chk #(.GATE_CYCLES(GATE_CYCLES)) u_chk (.clk(clk), .rst(rst),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .a_in(a_in),
    .b_in(b_in), .trig_in(trig_in), .reading_avail(reading_avail));

/* verif/mmec_pulse_src.sv */
`timescale 1ns/1ps
module mmec_pulse_src
(
    input wire logic clk,
    output logic a,
    output logic b
);
    initial
    begin
        a = 1'b0;
        b = 1'b0;
    end
    // Levels last whole clock cycles so that measured intervals come out exact.
    task automatic pulse(input logic on_b, input int hi, input int lo);
        if (on_b)
            b <= 1'b1;
        else
            a <= 1'b1;
        repeat (hi) @(posedge clk);
        if (on_b)
            b <= 1'b0;
        else
            a <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask
    task automatic set_a(input logic v);
        a <= v;
        @(posedge clk);
    endtask
    task automatic set_b(input logic v);
        b <= v;
        @(posedge clk);
    endtask
endmodule // mmec_pulse_src

/* verif/multi_mode_event_counter_tb_top.sv */
`timescale 1ns/1ps
module multi_mode_event_counter_tb_top
    import mmec_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic trig_in = 1'b0;
    logic rd_d = 1'b0;
    logic ce = 1'b1;
    wire [31:0] rdata;
    wire a_in;
    wire b_in;
    wire reading_avail;
    int failures = 0;
    int compares = 0;
    int n1;
    int n2;
    logic [31:0] exp_q[$];
    string name_q[$];
    always #4 clk = ~clk;
    mmec_channel #(.GATE_CYCLES(200)) uut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .a_in(a_in), .b_in(b_in),
        .trig_in(trig_in), .reading_avail(reading_avail));
    mmec_pulse_src src (.clk(clk), .a(a_in), .b(b_in));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk)
    begin
        if (rd_d)
            chk(name_q.pop_front(), exp_q.pop_front(), rdata);
    end
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        name_q.push_back(nm);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic avail_is(input logic e);
        @(negedge clk);
        chk("reading_avail", {31'h0, e}, {31'h0, reading_avail});
        @(posedge clk);
    endtask
    task automatic wait_avail;
        for (int i = 0; i < 100 && reading_avail !== 1'b1; i++)
            @(posedge clk);
        avail_is(1'b1);
    endtask
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #200000;
        failures++;
        final_report();
    end
    initial
    begin
        n1 = $urandom(24437);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++)
            rd_chk("reset value", 8'(i * 4), (i == 1) ? 32'h2 : 32'h0);
        $display("test reset values done");
        wr_reg(MMEC_REG_LIMIT, 32'h3);
        wr_reg(MMEC_REG_CTRL, 32'h080);
        src.pulse(1'b0, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'h0);
        wr_reg(MMEC_REG_CTRL, 32'h180);
        repeat (2) src.pulse(1'b0, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'h2);
        src.pulse(1'b0, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'h0);
        src.pulse(1'b1, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'h2);
        ce <= 1'b0;
        src.pulse(1'b0, 6, 6);
        ce <= 1'b1;
        rd_chk("count", MMEC_REG_COUNT, 32'h2);
        avail_is(1'b0);
        $display("test modulo up down done");
        n1 = $urandom_range(2, 5);
        n2 = $urandom_range(3, 7);
        wr_reg(MMEC_REG_CTRL, 32'h141);
        src.set_b(1'b1);
        repeat (n1) src.pulse(1'b0, 6, 6);
        src.set_b(1'b0);
        repeat (n2) src.pulse(1'b0, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'(n1 - n2));
        wr_reg(MMEC_REG_CTRL, 32'h101);
        repeat (2) src.pulse(1'b0, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'h2);
        wr_reg(MMEC_REG_LIMIT, 32'h4);
        wr_reg(MMEC_REG_CTRL, 32'h142);
        src.pulse(1'b0, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'h3);
        src.set_b(1'b1);
        src.pulse(1'b0, 6, 6);
        rd_chk("count", MMEC_REG_COUNT, 32'h0);
        wr_reg(MMEC_REG_CTRL, 32'h1E1);
        src.set_a(1'b1);
        src.set_b(1'b0);
        src.set_a(1'b0);
        repeat (4) @(posedge clk);
        rd_chk("count", MMEC_REG_COUNT, 32'h2);
        avail_is(1'b0);
        $display("test count direction done");
        n1 = $urandom_range(1, 4);
        wr_reg(MMEC_REG_LIMIT, 32'h2);
        wr_reg(MMEC_REG_CTRL, 32'h093);
        trig_in <= 1'b1;
        repeat (6) @(posedge clk);
        trig_in <= 1'b0;
        repeat (2)
        begin
            src.pulse(1'b1, 6, 6);
            repeat (2 * n1) src.pulse(1'b0, 4, 4);
        end
        src.pulse(1'b1, 6, 6);
        wait_avail();
        rd_chk("ratio", MMEC_REG_RESULT, 32'(2 * n1));
        rd_chk("status", MMEC_REG_STATUS, 32'h2);
        wr_reg(MMEC_REG_STATUS, 32'h2);
        rd_chk("status", MMEC_REG_STATUS, 32'h0);
        avail_is(1'b0);
        $display("test ratio done");
        n2 = $urandom_range(20, 40);
        wr_reg(MMEC_REG_CTRL, 32'h104);
        repeat (3) src.pulse(1'b0, n2 / 2, n2 - n2 / 2);
        repeat (60) @(posedge clk);
        rd_chk("period", MMEC_REG_RESULT, 32'(n2));
        rd_chk("status", MMEC_REG_STATUS, 32'h2);
        avail_is(1'b0);
        wr_reg(MMEC_REG_STATUS, 32'h2);
        $display("test averaged period done");
        wr_reg(MMEC_REG_CTRL, 32'h1C5);
        src.set_b(1'b0);
        src.pulse(1'b0, 10, 10);
        src.set_b(1'b1);
        src.pulse(1'b0, 15, 15);
        src.pulse(1'b0, 10, 10);
        src.pulse(1'b0, 25, 25);
        wait_avail();
        rd_chk("gated period", MMEC_REG_RESULT, 32'h14);
        wr_reg(MMEC_REG_STATUS, 32'h2);
        $display("test gated period done");
        wr_reg(MMEC_REG_CTRL, 32'h18E);
        repeat (12) src.pulse(1'b0, 10, 10);
        wait_avail();
        rd_chk("frequency", MMEC_REG_RESULT, 32'hA);
        wr_reg(MMEC_REG_STATUS, 32'h2);
        $display("test frequency done");
        final_report();
    end
endmodule // multi_mode_event_counter_tb_top
